/* File: rtl/byte_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
        begin : g_bad
            $error("byte_fifo: depth must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic push, pop, full, empty;

    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready_out = ~full;
    assign out_valid_out = ~empty;
    assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];
    assign push = in_valid_in & ~full;
    assign pop = out_ready_in & ~empty;

    always_comb
    begin
        wr_ptr_next = wr_ptr_reg + (AW+1)'(push);
        rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk_in)
        begin
            if (push && wr_ptr_reg[AW-1:0] == AW'(i))
            begin
                mem_reg[i] <= in_data_in;
            end
        end
    end

endmodule
`default_nettype wire

/* File: rtl/cfg_loader.sv */
// i2c/i3c target configuration loader: bit capture on scl, stream engine
// assumes scl/sda from an open-drain bus and a fabric sink with ready
`timescale 1ns/1ps
`default_nettype none
module cfg_loader
    import cfg_loader_pkg::*;
#(
    parameter logic [6:0] STATIC_ADDR = STATIC_ADDR_DEF,
    parameter int WAIT_PLAIN = WAIT_PLAIN_CYC,
    parameter int WAIT_ENC = WAIT_ENC_CYC,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [LEN_W-1:0] stream_len_in,
    input wire logic cfg_ready_in,
    output logic [7:0] cfg_data_out,
    output logic cfg_valid_out,
    input wire logic done_pin_in,
    output logic done_pin_out,
    output logic done_pin_oe_out,
    output logic io_wake_out,
    output logic user_mode_out,
    output logic done_out,
    output logic auth_complete_flag_out,
    output logic busy_out,
    output logic abort_err_out,
    output logic illegal_cmd_err_out,
    output logic crc_err_out,
    output logic erase_out
);
    generate
        if (WAIT_PLAIN < 1 || WAIT_ENC < 1 ||
            WAIT_PLAIN >= (1 << TIMER_W) || WAIT_ENC >= (1 << TIMER_W))
        begin : g_bad
            $error("cfg_loader: wait counts out of timer range");
        end
    endgenerate

    function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                             input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
        begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // mclk registers read by the link side
    logic [6:0] dyn_addr_reg, dyn_addr_next;
    logic dyn_valid_reg, dyn_valid_next;
    logic fifo_rdy_reg, stop_tgl_reg;

    // link domain, rising scl edge
    logic lrst_s1_reg, lrst_s2_reg, rdy_s1_reg, rdy_s2_reg;
    logic dv_s1_reg, dv_s2_reg, stop_s2_reg, stop_seen_reg;
    logic sda_pos_reg;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic first_reg, first_next, tgl_reg, tgl_next, ack_reg, ack_next;
    link_byte_s hold_reg, hold_next;
    // link domain, falling scl edge
    logic start_neg_reg, stop_s1_reg, sda_oe_reg;
    logic restart;

    assign restart = start_neg_reg | (stop_s2_reg != stop_seen_reg);

    always_comb
    begin
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        first_next = first_reg;
        tgl_next = tgl_reg;
        ack_next = ack_reg;
        hold_next = hold_reg;
        if (restart)
        begin
            // a start after a stop lands one bit late; keep that bit
            bit_cnt_next = start_neg_reg ? 4'h1 : 4'h2;
            shift_next = start_neg_reg ? {7'h00, sda_in} :
                {6'h00, shift_reg[0], sda_in};
            first_next = 1'b1;
            ack_next = 1'b0;
        end
        else if (bit_cnt_reg == BITS_PER_BYTE)
        begin
            bit_cnt_next = 4'h0;
        end
        else
        begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
            shift_next = {shift_reg[6:0], sda_in};
            if (bit_cnt_next == BITS_PER_BYTE)
            begin
                hold_next = '{stop: 1'b0, first: first_reg,
                              data: shift_next};
                tgl_next = ~tgl_reg;
                first_next = 1'b0;
                if (first_reg)
                begin
                    ack_next = ~shift_next[0] &&
                        (shift_next[7:1] == STATIC_ADDR ||
                         shift_next[7:1] == BCAST_ADDR ||
                         (dv_s2_reg && shift_next[7:1] == dyn_addr_reg));
                end
                else
                begin
                    ack_next = ack_reg & rdy_s2_reg;
                end
            end
        end
    end

    always_ff @(posedge scl_in)
    begin
        lrst_s1_reg <= rst_in;
        lrst_s2_reg <= lrst_s1_reg;
        rdy_s1_reg <= fifo_rdy_reg;
        rdy_s2_reg <= rdy_s1_reg;
        dv_s1_reg <= dyn_valid_reg;
        dv_s2_reg <= dv_s1_reg;
        stop_s2_reg <= stop_s1_reg;
        sda_pos_reg <= sda_in;
        if (lrst_s2_reg)
        begin
            stop_seen_reg <= stop_s2_reg;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_reg <= 1'b0;
            tgl_reg <= 1'b0;
            ack_reg <= 1'b0;
            hold_reg <= '0;
        end
        else
        begin
            stop_seen_reg <= stop_s2_reg;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            first_reg <= first_next;
            tgl_reg <= tgl_next;
            ack_reg <= ack_next;
            hold_reg <= hold_next;
        end
    end

    // start: sda fell while scl was high; ack drive in the ninth slot
    always_ff @(negedge scl_in)
    begin
        stop_s1_reg <= stop_tgl_reg;
        if (lrst_s2_reg)
        begin
            start_neg_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            start_neg_reg <= sda_pos_reg & ~sda_in;
            sda_oe_reg <= (bit_cnt_reg == BITS_PER_BYTE) & ack_reg;
        end
    end

    assign sda_oe_out = sda_oe_reg;

    // pin and toggle synchronisers into mclk
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
    logic dpin_s1_reg, dpin_s2_reg;
    logic stop_pend_reg, stop_pend_next, stop_det, byte_ev;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
    link_byte_s fifo_in, fifo_out;

    assign stop_det = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;
    assign byte_ev = tgl_s2_reg ^ tgl_s3_reg;
    assign fifo_in_valid = byte_ev | stop_pend_reg;

    always_comb
    begin
        fifo_in = hold_reg;
        if (!byte_ev)
        begin
            fifo_in = '{stop: 1'b1, first: 1'b0, data: 8'h00};
        end
        stop_pend_next = stop_det |
            (stop_pend_reg & ~(~byte_ev & fifo_in_ready));
    end

    always_ff @(posedge mclk_in)
    begin
        scl_s1_reg <= scl_in;
        scl_s2_reg <= scl_s1_reg;
        scl_s3_reg <= scl_s2_reg;
        sda_s1_reg <= sda_in;
        sda_s2_reg <= sda_s1_reg;
        sda_s3_reg <= sda_s2_reg;
        tgl_s1_reg <= tgl_reg;
        tgl_s2_reg <= tgl_s1_reg;
        tgl_s3_reg <= tgl_s2_reg;
        dpin_s1_reg <= done_pin_in;
        dpin_s2_reg <= dpin_s1_reg;
        if (rst_in)
        begin
            stop_pend_reg <= 1'b0;
            stop_tgl_reg <= 1'b0;
            fifo_rdy_reg <= 1'b0;
        end
        else
        begin
            stop_pend_reg <= stop_pend_next;
            stop_tgl_reg <= stop_tgl_reg ^ stop_det;
            fifo_rdy_reg <= fifo_in_ready;
        end
    end

    byte_fifo #(
        .WIDTH($bits(link_byte_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out)
    );

    // config_stream_engine
    eng_state_e state_reg, state_next;
    logic [LEN_W-1:0] rem_reg, rem_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic [7:0] crc_reg, crc_next, data_reg, data_next;
    logic valid_reg, valid_next, enc_reg, enc_next, load_reg, load_next;
    logic dasa_reg, dasa_next, oe_reg, oe_next, erase_reg, erase_next;
    logic wake_reg, wake_next, user_reg, user_next;
    logic done_reg, done_next, auth_reg, auth_next;
    logic abort_reg, abort_next, ill_reg, ill_next, crcerr_reg, crcerr_next;
    logic busy_reg;

    assign fifo_pop = fifo_out_valid & (~valid_reg | cfg_ready_in);

    always_comb
    begin
        state_next = state_reg;
        rem_next = rem_reg;
        timer_next = timer_reg;
        crc_next = crc_reg;
        data_next = data_reg;
        valid_next = valid_reg & ~cfg_ready_in;
        enc_next = enc_reg;
        load_next = load_reg;
        dasa_next = dasa_reg;
        dyn_addr_next = dyn_addr_reg;
        dyn_valid_next = dyn_valid_reg;
        oe_next = oe_reg;
        erase_next = 1'b0;
        wake_next = wake_reg;
        user_next = user_reg;
        done_next = done_reg;
        auth_next = auth_reg;
        abort_next = abort_reg;
        ill_next = ill_reg;
        crcerr_next = crcerr_reg;
        if (fifo_pop && fifo_out.stop)
        begin
            if (load_reg)
            begin
                abort_next = 1'b1;
                load_next = 1'b0;
            end
            if (state_reg != ST_WAIT && state_reg != ST_RELEASE &&
                state_reg != ST_WAKE)
            begin
                state_next = ST_IDLE;
            end
        end
        else if (fifo_pop && fifo_out.first &&
                 state_reg != ST_WAIT && state_reg != ST_RELEASE &&
                 state_reg != ST_WAKE)
        begin
            if (load_reg && fifo_out.data[7:1] != BCAST_ADDR)
            begin
                state_next = ST_LOAD;
            end
            else if (fifo_out.data[7:1] == BCAST_ADDR)
            begin
                state_next = ST_CCC;
            end
            else if (dasa_reg && fifo_out.data[7:1] == STATIC_ADDR)
            begin
                state_next = ST_DASA;
            end
            else
            begin
                state_next = ST_CMD;
            end
        end
        else if (fifo_pop)
        begin
            case (state_reg)
                ST_CMD:
                begin
                    state_next = ST_SKIP;
                    if ((fifo_out.data == CMD_LOAD_PLAIN ||
                         fifo_out.data == CMD_LOAD_ENC) &&
                        stream_len_in > LEN_W'(1))
                    begin
                        state_next = ST_LOAD;
                        abort_next = 1'b0;
                        ill_next = 1'b0;
                        crcerr_next = 1'b0;
                        done_next = 1'b0;
                        auth_next = 1'b0;
                        oe_next = 1'b1;
                        load_next = 1'b1;
                        enc_next = (fifo_out.data == CMD_LOAD_ENC);
                        rem_next = stream_len_in;
                        crc_next = CRC_INIT;
                        // io banks wake at stream start
                        wake_next = 1'b1;
                    end
                    else if (fifo_out.data == CMD_FRAME)
                    begin
                        state_next = ST_FRAME;
                    end
                    else if (fifo_out.data == CMD_ERASE)
                    begin
                        erase_next = 1'b1;
                    end
                    // misaligned bits decode as bad command
                    else if (fifo_out.data != CMD_BUSY)
                    begin
                        ill_next = 1'b1;
                    end
                end
                ST_LOAD:
                begin
                    if (rem_reg > LEN_W'(1))
                    begin
                        data_next = fifo_out.data;
                        valid_next = 1'b1;
                        crc_next = crc8_step(crc_reg, fifo_out.data);
                        rem_next = rem_reg - LEN_W'(1);
                    end
                    else
                    begin
                        crcerr_next = (fifo_out.data != crc_reg);
                        load_next = 1'b0;
                        state_next = ST_WAIT;
                        timer_next = enc_reg ? TIMER_W'(WAIT_ENC - 1) :
                                               TIMER_W'(WAIT_PLAIN - 1);
                    end
                end
                ST_FRAME:
                begin
                    data_next = fifo_out.data;
                    valid_next = 1'b1;
                end
                ST_CCC:
                begin
                    state_next = ST_SKIP;
                    if (fifo_out.data == CCC_RSTDAA)
                    begin
                        dyn_valid_next = 1'b0;
                    end
                    else if (fifo_out.data == CCC_SETDASA)
                    begin
                        dasa_next = 1'b1;
                    end
                end
                ST_DASA:
                begin
                    dyn_addr_next = fifo_out.data[7:1];
                    dyn_valid_next = 1'b1;
                    dasa_next = 1'b0;
                    state_next = ST_SKIP;
                end
                default:
                begin
                end
            endcase
        end
        else
        begin
            case (state_reg)
                ST_WAIT:
                begin
                    // done and auth flags rise only after the wait; a load command clears them
                    if (timer_reg == '0)
                    begin
                        state_next = crcerr_reg ? ST_IDLE : ST_RELEASE;
                        done_next = ~crcerr_reg;
                        auth_next = enc_reg & ~crcerr_reg;
                    end
                    else
                    begin
                        timer_next = timer_reg - TIMER_W'(1);
                    end
                end
                ST_RELEASE:
                begin
                    // pin released after flags are set
                    oe_next = 1'b0;
                    state_next = ST_WAKE;
                end
                ST_WAKE:
                begin
                    // wait for pin high; user mode
                    if (dpin_s2_reg)
                    begin
                        user_next = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
            rem_reg <= '0;
            timer_reg <= '0;
            crc_reg <= CRC_INIT;
            data_reg <= 8'h00;
            valid_reg <= 1'b0;
            enc_reg <= 1'b0;
            load_reg <= 1'b0;
            dasa_reg <= 1'b0;
            dyn_addr_reg <= 7'h00;
            dyn_valid_reg <= 1'b0;
            oe_reg <= DONE_OE_RST;
            erase_reg <= 1'b0;
            wake_reg <= 1'b0;
            user_reg <= 1'b0;
            done_reg <= 1'b0;
            auth_reg <= 1'b0;
            abort_reg <= 1'b0;
            ill_reg <= 1'b0;
            crcerr_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            rem_reg <= rem_next;
            timer_reg <= timer_next;
            crc_reg <= crc_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            enc_reg <= enc_next;
            load_reg <= load_next;
            dasa_reg <= dasa_next;
            dyn_addr_reg <= dyn_addr_next;
            dyn_valid_reg <= dyn_valid_next;
            oe_reg <= oe_next;
            erase_reg <= erase_next;
            wake_reg <= wake_next;
            user_reg <= user_next;
            done_reg <= done_next;
            auth_reg <= auth_next;
            abort_reg <= abort_next;
            ill_reg <= ill_next;
            crcerr_reg <= crcerr_next;
            busy_reg <= load_next | (state_next == ST_WAIT) |
                        (state_next == ST_RELEASE);
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge scl_in)
    begin
        sda_out <= 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        done_pin_out <= 1'b0;
    end

    assign done_pin_oe_out = oe_reg;
    assign cfg_data_out = data_reg;
    assign cfg_valid_out = valid_reg;
    assign io_wake_out = wake_reg;
    assign user_mode_out = user_reg;
    assign done_out = done_reg;
    assign auth_complete_flag_out = auth_reg;
    assign busy_out = busy_reg;
    assign abort_err_out = abort_reg;
    assign illegal_cmd_err_out = ill_reg;
    assign crc_err_out = crcerr_reg;
    assign erase_out = erase_reg;

endmodule
`default_nettype wire

/* File: rtl/cfg_loader_pkg.sv */
// constants, packed types and timing counts for the i2c/i3c config loader
// assumes a 125 MHz system clock and a bus controller that clocks scl
package cfg_loader_pkg;

    // target address; value is arbitrary
    localparam logic [6:0] STATIC_ADDR_DEF = 7'h40;
    localparam logic [6:0] BCAST_ADDR = 7'h7e;

    localparam logic [7:0] CMD_LOAD_PLAIN = 8'h7a;
    localparam logic [7:0] CMD_LOAD_ENC = 8'h7b;
    localparam logic [7:0] CMD_FRAME = 8'h70;
    localparam logic [7:0] CMD_ERASE = 8'h0e;
    localparam logic [7:0] CMD_BUSY = 8'hf0;
    localparam logic [7:0] CCC_RSTDAA = 8'h06;
    localparam logic [7:0] CCC_SETDASA = 8'h87;

    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic DONE_OE_RST = 1'b1;

    localparam int LEN_W = 24;
    localparam int TIMER_W = 24;
    localparam int FIFO_DEPTH_DEF = 4;

    localparam real CLK_PERIOD_NS = 8.0;
    localparam real WAIT_PLAIN_US = 60.0;
    localparam real WAIT_ENC_MS = 102.06;
    localparam int WAIT_PLAIN_CYC =
        int'($ceil(WAIT_PLAIN_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int WAIT_ENC_CYC =
        int'($ceil(WAIT_ENC_MS * 1.0e6 / CLK_PERIOD_NS));

    localparam int SCL_MAX_I2C_MHZ = 1;
    localparam int SCL_MAX_I3C_MHZ = 12;

    typedef struct packed {
        logic stop;
        logic first;
        logic [7:0] data;
    } link_byte_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CMD,
        ST_LOAD,
        ST_FRAME,
        ST_CCC,
        ST_DASA,
        ST_SKIP,
        ST_WAIT,
        ST_RELEASE,
        ST_WAKE
    } eng_state_e;

endpackage

/* File: testbench/bus_ctrl_model.sv */
// bus controller model: open-drain writer, 80 ns scl
// bench resolves sda; scl idles high between frames
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    logic ack_reg;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // clocks with sda high keep the link reset chain moving
    task automatic idle_clk(input int n);
        repeat (n)
        begin
            #40 scl_out = 1'b0;
            #40 scl_out = 1'b1;
        end
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        #20 scl_out = 1'b1;
        #40 sda_low_out = 1'b1;
        #40 scl_out = 1'b0;
        #20;
    endtask
    task automatic wbyte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low_out = (i > 0) && !b[i - 1];
            #20 scl_out = 1'b1;
            ack_reg = (i == 0) && !sda_in;
            #40 scl_out = 1'b0;
            #20;
        end
    endtask
    // stop only when the caller asks
    task automatic stop();
        sda_low_out = 1'b1;
        #20 scl_out = 1'b1;
        #40 sda_low_out = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire

/* File: testbench/cfg_loader_chk.sv */
// assertions on the cfg_loader top ports, mclk domain
// bound into every cfg_loader instance
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_chk #(
    parameter int WAIT_PLAIN = 20
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cfg_ready_in,
    input wire logic cfg_valid_out,
    input wire logic [7:0] cfg_data_out,
    input wire logic done_pin_in,
    input wire logic done_pin_oe_out,
    input wire logic user_mode_out,
    input wire logic done_out,
    input wire logic auth_complete_flag_out,
    input wire logic busy_out,
    input wire logic abort_err_out,
    input wire logic illegal_cmd_err_out,
    input wire logic crc_err_out,
    input wire logic erase_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    int quiet_reg;
    int quiet_next;
    // cycles since the last payload handoff
    always_comb quiet_next = (cfg_valid_out && cfg_ready_in) ? 0
        : quiet_reg + 1;
    always_ff @(posedge mclk_in) quiet_reg <= rst_in ? 0 : quiet_next;
    sequence pin_low4;
        (!done_pin_in) [*4];
    endsequence
    a_pin_after_flag: assert property (
        $fell(done_pin_oe_out) |-> $past(done_out)) else $error("pin early");
    a_wake_held: assert property (
        pin_low4 |=> !$rose(user_mode_out)) else $error("wake not held");
    a_user_after_done: assert property (
        $rose(user_mode_out) |-> done_out) else $error("user too early");
    a_auth_with_done: assert property (
        $rose(auth_complete_flag_out) |-> $rose(done_out))
        else $error("auth apart");
    a_wait_elapsed: assert property (
        $rose(done_out) |-> quiet_reg >= WAIT_PLAIN) else $error("no wait");
    a_abort_idle: assert property (
        $rose(abort_err_out) |-> !done_out ##1 !busy_out)
        else $error("abort busy");
    a_err_hold: assert property (
        $fell(abort_err_out) || $fell(crc_err_out)
        || $fell(illegal_cmd_err_out) |-> ##[0:2] busy_out)
        else $error("error lost");
    a_erase_pulse: assert property (
        erase_out |=> !erase_out) else $error("erase long");
    a_valid_hold: assert property (
        cfg_valid_out && !cfg_ready_in |=> cfg_valid_out
        && $stable(cfg_data_out)) else $error("byte dropped");
endmodule
bind cfg_loader cfg_loader_chk #(.WAIT_PLAIN(WAIT_PLAIN)) i_chk (.*);
`default_nettype wire

/* File: testbench/cfg_loader_tb.sv */
// bench for cfg_loader: bus model writes, flags checked
// needs cfg_loader_pkg and bus_ctrl_model compiled first
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_tb;
    import cfg_loader_pkg::*;
    localparam logic [7:0] ADR = {STATIC_ADDR_DEF, 1'b0};
    logic mclk_in, rst_in, scl_in, sda_in, sda_out, sda_oe_out, sda_low;
    logic cfg_ready_in, cfg_valid_out, done_pin_in, done_pin_out, hold;
    logic done_pin_oe_out, io_wake_out, user_mode_out, done_out, busy_out;
    logic auth_complete_flag_out, abort_err_out, illegal_cmd_err_out;
    logic crc_err_out, erase_out;
    logic [7:0] cfg_data_out, flags;
    logic [LEN_W-1:0] stream_len_in;
    logic [7:0] sent[$], got[$];
    logic [7:0] cmds[3] = '{CMD_ERASE, CMD_BUSY, 8'h55};
    int n_errors = 0, samples_checked = 0, cyc = 0, n_erase = 0;
    assign sda_in = !(sda_low || sda_oe_out);
    assign done_pin_in = !(done_pin_oe_out || hold);
    assign flags = {1'b0, done_out, auth_complete_flag_out, user_mode_out,
        abort_err_out, illegal_cmd_err_out, crc_err_out, io_wake_out};
    cfg_loader #(.WAIT_PLAIN(20), .WAIT_ENC(40)) i_cfg_loader (.*);
    bus_ctrl_model i_bus (.sda_in, .scl_out(scl_in), .sda_low_out(sda_low));
    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        cyc++;
        n_erase += erase_out;
        if (cfg_valid_out && cfg_ready_in)
            got.push_back(cfg_data_out);
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, got_v);
        @(negedge mclk_in);
        samples_checked++;
        if (got_v !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got_v);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] d[$]);
        logic [7:0] c;
        c = CRC_INIT;
        foreach (d[i])
        begin
            c ^= d[i];
            repeat (8) c = c[7] ? (c << 1) ^ CRC_POLY : c << 1;
        end
        return c;
    endfunction
    task automatic tx(input logic [7:0] q[$], input logic rs);
        i_bus.start();
        foreach (q[i]) i_bus.wbyte(q[i]);
        if (!rs) i_bus.stop();
    endtask
    task automatic load(input logic [7:0] cmd, input int n, cut, extra,
        input logic [7:0] bad);
        logic [7:0] q[$];
        @(negedge mclk_in);
        stream_len_in = LEN_W'(n + 1 + extra);
        sent.delete();
        got.delete();
        for (int i = 0; i < n; i++)
            sent.push_back(8'(90 + 37 * i));
        q = {ADR, cmd, sent, crc8(sent) ^ bad};
        if (cut > 0)
        begin
            tx(q[0:cut + 1], 1'b1);
            q = {ADR, q[cut + 2:$]};
        end
        @(negedge mclk_in);
        cfg_ready_in = 1'b1;
        tx(q, 1'b0);
    endtask
    initial
    begin
        {rst_in, hold, cfg_ready_in} = 3'b110;
        stream_len_in = '0;
        #13 i_bus.idle_clk(4);
        @(negedge mclk_in) rst_in = 1'b0;
        i_bus.idle_clk(2);
        chk("flags", 8'h00, flags);
        load(CMD_LOAD_PLAIN, 3, 1, 0, 8'h00);
        repeat (80) @(negedge mclk_in);
        chk("flags", 8'h41, flags);
        foreach (sent[i]) chk("byte", sent[i], got[i]);
        hold = 1'b0;
        repeat (4) @(negedge mclk_in);
        chk("flags", 8'h51, flags);
        load(CMD_LOAD_ENC, 1, 0, 0, 8'h00);
        repeat (80) @(negedge mclk_in);
        chk("flags", 8'h71, flags);
        load(CMD_LOAD_PLAIN, 2, 0, 4, 8'h00);
        chk("flags", 8'h19, flags);
        load(CMD_FRAME, 1, 0, 0, 8'h00);
        chk("frame", sent[0], got[0]);
        chk("flags", 8'h19, flags);
        load(CMD_LOAD_PLAIN, 2, 0, 0, 8'h01);
        repeat (80) @(negedge mclk_in);
        chk("flags", 8'h13, flags);
        foreach (cmds[i]) tx('{ADR, cmds[i]}, 1'b0);
        chk("flags", 8'h17, flags);
        chk("erase", 8'h01, 8'(n_erase));
        tx('{8'hfc, CCC_RSTDAA}, 1'b0);
        tx('{8'hfc, CCC_SETDASA}, 1'b1);
        tx('{ADR, 8'h44}, 1'b0);
        tx('{8'h44}, 1'b0);
        chk("dyn_ack", 8'h01, 8'(i_bus.ack_reg));
        tx('{8'h46}, 1'b0);
        chk("bad_ack", 8'h00, 8'(i_bus.ack_reg));
        finish_test();
    end
endmodule
`default_nettype wire
